/* File: secl_loader.sv */
// serial memory controller: presence check, image download, random access
// assumes a mode-0 serial memory with pull-up on its data output
//
// Operation
// - drive select, clock, data out; sample data in; clock at most 17.86 MHz
// - find one, two or three address bytes without software help
// - software reads and writes memory four bytes at a time
// - in NT mode serve expansion ROM reads up to 32 KB
// - refuse expansion ROM reads when memory uses one address byte
// - download only if present, signature 5Ah and a reset event seen
// - fundamental reset returning high triggers a download
// - hot reset triggers a download unless debug bit 17 or 16 set
// - leaving link down triggers a download unless debug bit 20 or 16 set
// - memory counts as present only for a non-zero status answer
// - returned status byte is reported as status data
// - presence field reads 01b when present, 00b otherwise
// - byte 0 must be 5Ah to count as valid; byte 1 reserved
// - bytes 2 and 3 give the entry byte count, low first
// - a trailing partial entry is dropped and writes nothing
// - each entry is locator low, high, then four value bytes
// - only registers named by entries are written
// - locator bits 9:0 give register dword address bits 11:2
// - locator bits 15:10 select the port; reserved codes write nothing
// - no checksum; the signature byte is the only check
// - bad signature stops reading and reports width 00b
// - three-bit rate select picks the clock; reset value gives 1 MHz
`timescale 1ns/1ps
`default_nettype none

module secl_loader (
  // clocks and resets
  input wire logic clock,
  input wire logic reset,
  input wire logic link_clock,
  input wire logic link_reset,
  // reset events
  input wire logic fundamental_reset_n,
  input wire logic link_hot_reset,
  input wire logic link_dl_down,
  // configuration
  input wire logic [2:0] serial_clock_rate_select,
  input wire logic dbg_hot_load_off,
  input wire logic dbg_upstream_hot_ctl,
  input wire logic dbg_dl_down_load_off,
  input wire logic nt_mode,
  // status
  output logic [7:0] memory_status_data,
  output logic [1:0] memory_presence_field,
  output logic [1:0] memory_addr_width_field,
  output logic image_valid,
  output logic load_busy,
  // register download
  output logic entry_write,
  output logic [15:0] entry_register_locator,
  output logic [31:0] entry_register_value,
  // random and expansion rom access
  input wire logic sw_req,
  input wire logic sw_write,
  input wire logic [23:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  output logic sw_ready,
  output logic sw_done,
  input wire logic rom_req,
  input wire logic [14:0] rom_addr,
  output logic rom_ready,
  output logic rom_done,
  output logic [31:0] access_rdata,
  // memory pins
  output logic mem_cs_n,
  output logic mem_sck,
  output logic mem_mosi,
  input wire logic mem_miso
);

  // link domain: edges become toggles so no pulse is lost crossing over
  logic hot_q, dl_q, hot_tgl, dl_tgl;
  logic next_hot_tgl, next_dl_tgl;

  always_comb begin
    next_hot_tgl = hot_tgl ^ (link_hot_reset && !hot_q);
    next_dl_tgl = dl_tgl ^ (!link_dl_down && dl_q);
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      hot_q <= 1'b0;
      dl_q <= 1'b0;
      hot_tgl <= 1'b0;
      dl_tgl <= 1'b0;
    end else begin
      hot_q <= link_hot_reset;
      dl_q <= link_dl_down;
      hot_tgl <= next_hot_tgl;
      dl_tgl <= next_dl_tgl;
    end
  end

  // core-side synchronisers; third stage only for edge detection
  logic f1, f2, f3, h1, h2, h3, d1, d2, d3, m1, m2;
  logic ev_fund, ev_hot, ev_dl;

  always_ff @(posedge clock) begin
    if (reset) begin
      {f1, f2, f3} <= 3'h0;
      {h1, h2, h3} <= 3'h0;
      {d1, d2, d3} <= 3'h0;
      {m1, m2} <= 2'h3;
    end else begin
      {f1, f2, f3} <= {fundamental_reset_n, f1, f2};
      {h1, h2, h3} <= {hot_tgl, h1, h2};
      {d1, d2, d3} <= {dl_tgl, d1, d2};
      {m1, m2} <= {mem_miso, m1};
    end
  end

  // a pin already high at release counts as a fresh power-up load
  assign ev_fund = f2 && !f3;
  assign ev_hot = (h2 ^ h3) && !(dbg_hot_load_off || dbg_upstream_hot_ctl);
  assign ev_dl = (d2 ^ d3) && !(dbg_dl_down_load_off || dbg_upstream_hot_ctl);

  // byte engine: mode 0, msb first
  logic eng_go, eng_busy, eng_done;
  logic [7:0] eng_tx, eng_rx, ecnt, ehalf, etx, erx;
  logic [2:0] ebit, rate;
  logic next_eng_busy, next_eng_done, next_sck, next_mosi;
  logic [7:0] next_eng_rx, next_ecnt, next_ehalf, next_etx, next_erx;
  logic [2:0] next_ebit;

  always_comb begin
    next_eng_busy = eng_busy;
    next_eng_done = 1'b0;
    next_sck = mem_sck;
    next_mosi = mem_mosi;
    next_eng_rx = eng_rx;
    next_ecnt = ecnt;
    next_ehalf = ehalf;
    next_etx = etx;
    next_erx = erx;
    next_ebit = ebit;
    if (eng_go) begin
      next_eng_busy = 1'b1;
      next_ehalf = secl_pkg::half_cycles(rate);
      next_ecnt = 8'h00;
      next_ebit = 3'h0;
      next_etx = eng_tx;
      next_mosi = eng_tx[7];
      next_sck = 1'b0;
    end else if (eng_busy) begin
      if (ecnt == ehalf - 8'h01) begin
        next_ecnt = 8'h00;
        if (!mem_sck) begin
          next_sck = 1'b1;
        end else begin
          // sample late in the high phase so the sync delay stays inside it
          next_sck = 1'b0;
          next_erx = {erx[6:0], m2};
          if (ebit == 3'h7) begin
            next_eng_busy = 1'b0;
            next_eng_done = 1'b1;
            next_eng_rx = {erx[6:0], m2};
          end else begin
            next_ebit = ebit + 3'h1;
            next_etx = {etx[6:0], 1'b0};
            next_mosi = etx[6];
          end
        end
      end else begin
        next_ecnt = ecnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      eng_busy <= 1'b0;
      eng_done <= 1'b0;
      mem_sck <= 1'b0;
      mem_mosi <= 1'b0;
      eng_rx <= 8'h00;
      ecnt <= 8'h00;
      ehalf <= 8'h01;
      etx <= 8'h00;
      erx <= 8'h00;
      ebit <= 3'h0;
      rate <= secl_pkg::RATE_SEL_RESET;
    end else begin
      eng_busy <= next_eng_busy;
      eng_done <= next_eng_done;
      mem_sck <= next_sck;
      mem_mosi <= next_mosi;
      eng_rx <= next_eng_rx;
      ecnt <= next_ecnt;
      ehalf <= next_ehalf;
      etx <= next_etx;
      erx <= next_erx;
      ebit <= next_ebit;
      rate <= serial_clock_rate_select;
    end
  end

  // sequencer
  secl_pkg::secl_state_t state, ret, next_state, next_ret;
  logic [2:0] idx, next_idx;
  logic [15:0] remain, next_remain, next_loc;
  logic [23:0] addr, next_addr;
  logic [31:0] next_val, next_data;
  logic [7:0] gcnt, next_gcnt, next_status, next_eng_tx, tx;
  logic [1:0] next_presence, next_width, weff, aix, dix;
  logic inflight, wr, is_rom, pending, issue;
  logic next_inflight, next_wr, next_is_rom, next_pending, next_busy, next_valid;
  logic next_go, next_cs_n, next_entry_write, next_sw_done, next_rom_done;
  logic next_sw_ready, next_rom_ready;

  always_comb begin
    next_state = state;
    next_ret = ret;
    next_idx = idx;
    next_remain = remain;
    next_loc = entry_register_locator;
    next_val = entry_register_value;
    next_addr = addr;
    next_data = access_rdata;
    next_gcnt = gcnt;
    next_status = memory_status_data;
    next_eng_tx = eng_tx;
    next_presence = memory_presence_field;
    next_width = memory_addr_width_field;
    next_inflight = inflight && !eng_done;
    next_wr = wr;
    next_is_rom = is_rom;
    next_pending = pending;
    next_busy = load_busy;
    next_valid = image_valid;
    next_go = 1'b0;
    next_cs_n = mem_cs_n;
    next_entry_write = 1'b0;
    next_sw_done = 1'b0;
    next_rom_done = 1'b0;
    issue = 1'b0;
    tx = 8'h00;
    // an undetermined width falls back to one address byte
    weff = (memory_addr_width_field == secl_pkg::WIDTH_UNDET) ? 2'h1 : memory_addr_width_field;
    aix = 2'(weff - idx[1:0]);
    dix = 2'(idx - {1'b0, weff} - 3'h1);
    unique case (state)
      secl_pkg::ST_IDLE: begin
        next_idx = 3'h0;
        if (sw_ready && sw_req) begin
          next_addr = {sw_addr[23:2], 2'b00};
          next_data = sw_wdata;
          next_wr = sw_write;
          next_is_rom = 1'b0;
          next_cs_n = 1'b0;
          next_state = sw_write ? secl_pkg::ST_WREN : secl_pkg::ST_ACC;
        end else if (rom_ready && rom_req) begin
          next_addr = {9'h000, rom_addr[14:2], 2'b00};
          next_wr = 1'b0;
          next_is_rom = 1'b1;
          next_cs_n = 1'b0;
          next_state = secl_pkg::ST_ACC;
        end else if (pending) begin
          next_pending = 1'b0;
          next_busy = 1'b1;
          next_cs_n = 1'b0;
          next_state = secl_pkg::ST_STAT;
        end
      end
      secl_pkg::ST_STAT: begin
        issue = 1'b1;
        tx = (idx == 3'h0) ? secl_pkg::CMD_RDSR : 8'h00;
        if (eng_done) begin
          next_idx = 3'h1;
          if (idx != 3'h0) begin
            next_status = eng_rx;
            next_state = secl_pkg::ST_GAP;
            next_cs_n = 1'b1;
            next_ret = secl_pkg::ST_IDLE;
            if (load_busy) begin
              next_presence = (eng_rx != 8'h00) ? secl_pkg::PRESENT : secl_pkg::ABSENT;
              if (eng_rx != 8'h00) begin
                next_ret = secl_pkg::ST_DET;
              end else begin
                next_busy = 1'b0;
              end
            end else if (eng_rx[secl_pkg::STATUS_WIP_BIT]) begin
              next_ret = secl_pkg::ST_STAT;
            end else begin
              next_sw_done = 1'b1;
            end
          end
        end
      end
      secl_pkg::ST_GAP: begin
        next_gcnt = gcnt + 8'h01;
        if (gcnt == secl_pkg::CS_GAP_CYC - 8'h01) begin
          next_gcnt = 8'h00;
          next_idx = 3'h0;
          next_state = ret;
          next_cs_n = (ret == secl_pkg::ST_IDLE);
        end
      end
      secl_pkg::ST_DET: begin
        // address zeros keep flowing; the signature shows one slot past the width
        issue = 1'b1;
        tx = (idx == 3'h0) ? secl_pkg::CMD_READ : 8'h00;
        if (eng_done) begin
          next_idx = idx + 3'h1;
          if (idx == 3'h0) begin
            next_idx = 3'h1;
          end else if (eng_rx == secl_pkg::SIG_VALID && idx >= 3'h2) begin
            next_width = 2'(idx - 3'h1);
            next_valid = 1'b1;
            next_state = secl_pkg::ST_HDR;
            next_idx = 3'h1;
          end else if (!(eng_rx == secl_pkg::BUS_IDLE && idx < secl_pkg::DET_LAST_SLOT)) begin
            next_width = secl_pkg::WIDTH_UNDET;
            next_valid = 1'b0;
            next_busy = 1'b0;
            next_state = secl_pkg::ST_GAP;
            next_cs_n = 1'b1;
            next_ret = secl_pkg::ST_IDLE;
          end
        end
      end
      secl_pkg::ST_HDR: begin
        issue = 1'b1;
        if (eng_done) begin
          next_idx = idx + 3'h1;
          if (idx == secl_pkg::HDR_CNT_LO) begin
            next_remain = {8'h00, eng_rx};
          end
          if (idx == secl_pkg::HDR_CNT_HI) begin
            next_remain = {eng_rx, remain[7:0]};
            next_state = secl_pkg::ST_ENT;
            next_idx = 3'h0;
          end
        end
      end
      secl_pkg::ST_ENT: begin
        if (idx == 3'h0 && !inflight && remain < secl_pkg::ENTRY_BYTES) begin
          next_busy = 1'b0;
          next_state = secl_pkg::ST_GAP;
          next_cs_n = 1'b1;
          next_ret = secl_pkg::ST_IDLE;
        end else begin
          issue = 1'b1;
        end
        if (eng_done) begin
          next_idx = idx + 3'h1;
          if (idx == 3'h0) begin
            next_loc[7:0] = eng_rx;
          end else if (idx == 3'h1) begin
            next_loc[15:8] = eng_rx;
          end else begin
            next_val[{2'(idx - 3'h2), 3'b000} +: 8] = eng_rx;
          end
          if (idx == secl_pkg::ENT_LAST) begin
            next_entry_write = secl_pkg::port_code_ok(entry_register_locator[15:10]);
            next_remain = remain - secl_pkg::ENTRY_BYTES;
            next_idx = 3'h0;
          end
        end
      end
      secl_pkg::ST_WREN: begin
        issue = 1'b1;
        tx = secl_pkg::CMD_WREN;
        if (eng_done) begin
          next_state = secl_pkg::ST_GAP;
          next_cs_n = 1'b1;
          next_ret = secl_pkg::ST_ACC;
        end
      end
      secl_pkg::ST_ACC: begin
        issue = 1'b1;
        if (idx == 3'h0) begin
          tx = wr ? secl_pkg::CMD_WRITE : secl_pkg::CMD_READ;
        end else if (idx <= {1'b0, weff}) begin
          tx = (aix == 2'h2) ? addr[23:16] : ((aix == 2'h1) ? addr[15:8] : addr[7:0]);
        end else begin
          tx = wr ? access_rdata[{dix, 3'b000} +: 8] : 8'h00;
        end
        if (eng_done) begin
          next_idx = idx + 3'h1;
          if (idx > {1'b0, weff} && !wr) begin
            next_data[{dix, 3'b000} +: 8] = eng_rx;
          end
          if (idx == {1'b0, weff} + 3'h4) begin
            next_state = secl_pkg::ST_GAP;
            next_cs_n = 1'b1;
            next_ret = wr ? secl_pkg::ST_STAT : secl_pkg::ST_IDLE;
            next_sw_done = !wr && !is_rom;
            next_rom_done = !wr && is_rom;
          end
        end
      end
    endcase
    if (issue && !inflight) begin
      next_go = 1'b1;
      next_eng_tx = tx;
      next_inflight = 1'b1;
    end
    // a new event beats the clear taken when a load starts
    if (ev_fund || ev_hot || ev_dl) begin
      next_pending = 1'b1;
    end
    next_sw_ready = (next_state == secl_pkg::ST_IDLE) && !next_busy && !next_pending;
    next_rom_ready = next_sw_ready && nt_mode && next_width[1];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= secl_pkg::ST_IDLE;
      ret <= secl_pkg::ST_IDLE;
      idx <= 3'h0;
      remain <= 16'h0000;
      entry_register_locator <= 16'h0000;
      entry_register_value <= 32'h0000_0000;
      addr <= 24'h00_0000;
      access_rdata <= 32'h0000_0000;
      gcnt <= 8'h00;
      memory_status_data <= 8'h00;
      eng_tx <= 8'h00;
      memory_presence_field <= secl_pkg::ABSENT;
      memory_addr_width_field <= secl_pkg::WIDTH_UNDET;
      inflight <= 1'b0;
      wr <= 1'b0;
      is_rom <= 1'b0;
      pending <= 1'b0;
      load_busy <= 1'b0;
      image_valid <= 1'b0;
      eng_go <= 1'b0;
      mem_cs_n <= 1'b1;
      entry_write <= 1'b0;
      sw_done <= 1'b0;
      rom_done <= 1'b0;
      sw_ready <= 1'b0;
      rom_ready <= 1'b0;
    end else begin
      state <= next_state;
      ret <= next_ret;
      idx <= next_idx;
      remain <= next_remain;
      entry_register_locator <= next_loc;
      entry_register_value <= next_val;
      addr <= next_addr;
      access_rdata <= next_data;
      gcnt <= next_gcnt;
      memory_status_data <= next_status;
      eng_tx <= next_eng_tx;
      memory_presence_field <= next_presence;
      memory_addr_width_field <= next_width;
      inflight <= next_inflight;
      wr <= next_wr;
      is_rom <= next_is_rom;
      pending <= next_pending;
      load_busy <= next_busy;
      image_valid <= next_valid;
      eng_go <= next_go;
      mem_cs_n <= next_cs_n;
      entry_write <= next_entry_write;
      sw_done <= next_sw_done;
      rom_done <= next_rom_done;
      sw_ready <= next_sw_ready;
      rom_ready <= next_rom_ready;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  chk_sck_high: assert property ($rose(mem_sck) |-> mem_sck [*6])
    else $error("serial clock high phase too short");
  chk_width_found: assert property (
    (state == secl_pkg::ST_DET && eng_done && eng_rx == secl_pkg::SIG_VALID && idx >= 3'h2)
    |=> memory_addr_width_field == 2'($past(idx) - 3'h1))
    else $error("address width not taken from signature slot");
  chk_rom_narrow: assert property (rom_ready |-> memory_addr_width_field[1] && nt_mode)
    else $error("rom service offered with narrow addressing");
  chk_write_valid: assert property (
    entry_write |-> image_valid && memory_presence_field == secl_pkg::PRESENT && load_busy)
    else $error("register written without a valid present image");
  chk_hot_gated: assert property (
    (ev_hot == 1'b0 && (h2 ^ h3) && !ev_fund && !ev_dl && !pending) |=> !pending)
    else $error("disabled hot reset started a load");
  chk_presence_copy: assert property (
    (state == secl_pkg::ST_STAT && load_busy && eng_done && idx == 3'h1)
    |=> memory_status_data == $past(eng_rx) && memory_presence_field ==
        (($past(eng_rx) != 8'h00) ? secl_pkg::PRESENT : secl_pkg::ABSENT))
    else $error("status copy or presence wrong");
  chk_bad_sig: assert property (
    (state == secl_pkg::ST_DET && eng_done && idx != 3'h0 && eng_rx != secl_pkg::SIG_VALID
     && eng_rx != secl_pkg::BUS_IDLE)
    |=> memory_addr_width_field == secl_pkg::WIDTH_UNDET && !load_busy ##1 mem_cs_n)
    else $error("bad signature did not stop the load");
  chk_partial_drop: assert property (
    (state == secl_pkg::ST_ENT && idx == 3'h0 && !inflight && remain < secl_pkg::ENTRY_BYTES)
    |=> !entry_write && !load_busy && state == secl_pkg::ST_GAP)
    else $error("partial entry not dropped");
  chk_port_code: assert property (entry_write |-> secl_pkg::port_code_ok(entry_register_locator[15:10]))
    else $error("reserved port code written");
  chk_busy_holdoff: assert property (load_busy |-> !sw_ready && !rom_ready && !sw_done)
    else $error("random access allowed during download");
  chk_cs_held: assert property (
    (state == secl_pkg::ST_HDR || state == secl_pkg::ST_ENT) && !(next_state == secl_pkg::ST_GAP)
    |-> !mem_cs_n)
    else $error("select released during download");

endmodule

`default_nettype wire

/* File: secl_loader_bench.sv */
// bench for the loader: downloads, reset events, random and rom reads
// assumes secl_pkg and the memory model are compiled first
`timescale 1ns/1ps
`default_nettype none

module secl_loader_bench;
  logic clock, reset = 1'b1, link_clock, link_reset = 1'b1;
  logic fundamental_reset_n = 1'b0, link_hot_reset = 1'b0, link_dl_down = 1'b0;
  logic [2:0] serial_clock_rate_select = 3'h4;
  logic dbg_hot_load_off = 1'b0, dbg_upstream_hot_ctl = 1'b0;
  logic dbg_dl_down_load_off = 1'b0, nt_mode = 1'b1;
  logic [7:0] memory_status_data, status = 8'h02;
  logic [1:0] memory_presence_field, memory_addr_width_field;
  logic image_valid, load_busy, entry_write, sw_ready, sw_done, rom_ready, rom_done;
  logic [15:0] entry_register_locator;
  logic [31:0] entry_register_value, access_rdata, sw_wdata = 32'h0000_0000;
  logic sw_req = 1'b0, sw_write = 1'b0, rom_req = 1'b0, mem_cs_n, mem_sck, mem_mosi, mem_miso;
  logic [23:0] sw_addr = 24'h00_0000;
  logic [14:0] rom_addr = 15'h0000;
  int error_cnt, checks_done;
  logic [47:0] got_q[$];
  // three entries, the middle one on a reserved port code, one stray byte
  // no debug control pair and no virtual-interface entry, so no strap dependence
  logic [7:0] img [0:22] = '{8'h5a, 8'h00, 8'h13, 8'h00, 8'h1f, 8'h04, 8'h44, 8'h33,
    8'h22, 8'h11, 8'h10, 8'h30, 8'haa, 8'hbb, 8'hcc, 8'hdd, 8'h05, 8'he0, 8'h88,
    8'h77, 8'h66, 8'h55, 8'h99};
  int hi_run = 0, hi_last = 0;

  secl_loader uut (.*);
  secl_mem_model #(.W(2)) mem (.cs_n(mem_cs_n), .sck(mem_sck), .mosi(mem_mosi),
    .miso(mem_miso), .status(status));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    // first link edge lands inside core reset so the toggles are never unknown
    #7;
    forever #80 link_clock = ~link_clock;
  end
  always @(negedge clock) begin
    if (entry_write === 1'b1) got_q.push_back({entry_register_locator, entry_register_value});
  end
  // length of the last serial clock high phase, in core cycles
  always @(negedge clock) begin
    if (mem_sck === 1'b1) hi_run <= hi_run + 1;
    else if (hi_run != 0) begin
      hi_last <= hi_run;
      hi_run <= 0;
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (s !== v && n < 20000);
    chk(48'(s), 48'(v));
  endtask
  task automatic acc(input logic rom, input logic wr, input logic [23:0] a,
      input logic [31:0] d);
    wait_for(sw_ready, 1'b1);
    @(posedge clock);
    if (rom) rom_req <= 1'b1;
    else sw_req <= 1'b1;
    sw_write <= wr;
    sw_addr <= a;
    rom_addr <= a[14:0];
    sw_wdata <= d;
    if (rom) wait_for(rom_ready, 1'b1);
    else wait_for(sw_ready, 1'b1);
    @(posedge clock);
    rom_req <= 1'b0;
    sw_req <= 1'b0;
    if (rom) wait_for(rom_done, 1'b1);
    else wait_for(sw_done, 1'b1);
  endtask
  task automatic link_pulse(input logic dl);
    @(posedge link_clock);
    if (dl) link_dl_down <= 1'b1;
    else link_hot_reset <= 1'b1;
    repeat (3) @(posedge link_clock);
    link_dl_down <= 1'b0;
    link_hot_reset <= 1'b0;
  endtask
  task automatic gated(input logic dl);
    link_pulse(dl);
    repeat (400) @(negedge clock);
    chk(48'(load_busy), 48'h0);
    chk(48'(got_q.size()), 48'h0);
  endtask
  task automatic check_load(input logic [1:0] w, input logic v, input int n);
    wait_for(load_busy, 1'b1);
    wait_for(load_busy, 1'b0);
    wait_for(sw_ready, 1'b1);
    chk(48'(memory_addr_width_field), 48'(w));
    chk(48'(image_valid), 48'(v));
    chk(48'(got_q.size()), 48'(n));
    if (n == 2) begin
      chk(got_q[0], {16'h041f, 32'h1122_3344});
      chk(got_q[1], {16'he005, 32'h5566_7788});
    end
    got_q.delete();
    $display("test load done");
  endtask

  initial begin
    repeat (4) @(posedge link_clock);
    link_reset <= 1'b0;
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    foreach (img[i]) mem.mem[i] = img[i];
    repeat (5) @(posedge clock);
    fundamental_reset_n <= 1'b1;
    check_load(2'h2, 1'b1, 2);
    chk(48'(memory_presence_field), 48'h1);
    chk(48'(memory_status_data), 48'h2);
    acc(1'b0, 1'b0, 24'h00_0040, 32'h0000_0000);
    chk(48'(access_rdata), 48'h4342_4140);
    acc(1'b0, 1'b1, 24'h00_0080, 32'hdead_beef);
    acc(1'b0, 1'b0, 24'h00_0080, 32'h0000_0000);
    chk(48'(access_rdata), 48'hdead_beef);
    acc(1'b1, 1'b0, 24'h00_0040, 32'h0000_0000);
    chk(48'(access_rdata), 48'h4342_4140);
    @(posedge clock);
    serial_clock_rate_select <= 3'h0;
    acc(1'b1, 1'b0, 24'h00_0040, 32'h0000_0000);
    chk(48'(access_rdata), 48'h4342_4140);
    chk(48'(hi_last), 48'(secl_pkg::CLK_KHZ / (2 * secl_pkg::RATE_1M_KHZ)));
    @(posedge clock);
    serial_clock_rate_select <= 3'h4;
    nt_mode <= 1'b0;
    repeat (2) @(negedge clock);
    chk(48'(rom_ready), 48'h0);
    @(posedge clock);
    nt_mode <= 1'b1;
    $display("test random access done");
    link_pulse(1'b0);
    check_load(2'h2, 1'b1, 2);
    @(posedge clock);
    dbg_hot_load_off <= 1'b1;
    dbg_dl_down_load_off <= 1'b1;
    gated(1'b0);
    gated(1'b1);
    @(posedge clock);
    dbg_hot_load_off <= 1'b0;
    dbg_dl_down_load_off <= 1'b0;
    dbg_upstream_hot_ctl <= 1'b1;
    gated(1'b0);
    gated(1'b1);
    @(posedge clock);
    dbg_upstream_hot_ctl <= 1'b0;
    $display("test gating done");
    mem.mem[0] = 8'h00;
    link_pulse(1'b1);
    check_load(2'h0, 1'b0, 0);
    chk(48'(rom_ready), 48'h0);
    status <= 8'h00;
    link_pulse(1'b0);
    check_load(2'h0, 1'b0, 0);
    chk(48'(memory_presence_field), 48'h0);
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 0, 1);
    give_verdict();
  end
endmodule

`default_nettype wire

/* File: secl_mem_model.sv */
// serial memory model: mode 0, msb first, data output pulled up when released
// assumes the loader's select, clock and data pins drive it directly
`timescale 1ns/1ps
`default_nettype none

module secl_mem_model #(
  parameter int W = 2
) (
  // memory pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // answer to a status read
  input wire logic [7:0] status
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, cmd, outb;
  logic [23:0] addr;
  logic drive;
  int bits, nbyte;
  // a released line floats to the pull-up level, never the last bit
  assign miso = (drive && !cs_n) ? outb[7] : 1'b1;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
  end
  always @(negedge cs_n) begin
    bits = 0;
    nbyte = 0;
    drive = 1'b0;
    addr = 24'h00_0000;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[6:0], mosi};
      bits = bits + 1;
      if (bits == 8) begin
        bits = 0;
        nbyte = nbyte + 1;
        if (nbyte == 1) cmd = sh;
        else if (nbyte <= W + 1) addr = {addr[15:0], sh};
        else if (cmd == 8'h02) begin
          mem[addr[7:0]] = sh;
          addr = addr + 24'h00_0001;
        end
      end
    end
  end
  // output bytes change on the falling edge, ready for the next rise
  always @(negedge sck) begin
    if (!cs_n && bits == 0 && nbyte > 0) begin
      drive = (cmd == 8'h05) || (cmd == 8'h03 && nbyte > W);
      outb = (cmd == 8'h05) ? status : mem[addr[7:0]];
      if (cmd == 8'h03 && nbyte > W) addr = addr + 24'h00_0001;
    end else if (!cs_n) outb = {outb[6:0], 1'b1};
  end
endmodule

`default_nettype wire

/* File: secl_pkg.sv */
// constants, encodings and states for the serial memory configuration loader
// assumes a 200 MHz core clock; all cycle counts below derive from it
package secl_pkg;

  localparam int CLK_KHZ = 200000;
  // fastest serial clock the memory link may run at
  localparam int SCK_MAX_KHZ = 17860;
  localparam int RATE_1M_KHZ = 1000;
  localparam int RATE_2M5_KHZ = 2500;
  localparam int RATE_5M_KHZ = 5000;
  localparam int RATE_9M62_KHZ = 9620;
  localparam logic [2:0] RATE_SEL_RESET = 3'h0;
  localparam int CS_GAP_NS = 100;

  function automatic int div_up(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

  localparam int SCK_MIN_HALF = div_up(CLK_KHZ, 2 * SCK_MAX_KHZ);
  localparam logic [7:0] CS_GAP_CYC = 8'(div_up(CS_GAP_NS * CLK_KHZ, 1000000));

  // half periods round up so no code runs faster than its nominal rate
  function automatic logic [7:0] half_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: return 8'(div_up(CLK_KHZ, 2 * RATE_1M_KHZ));
      3'h1: return 8'(div_up(CLK_KHZ, 2 * RATE_2M5_KHZ));
      3'h2: return 8'(div_up(CLK_KHZ, 2 * RATE_5M_KHZ));
      3'h3: return 8'(div_up(CLK_KHZ, 2 * RATE_9M62_KHZ));
      default: return 8'(SCK_MIN_HALF);
    endcase
  endfunction

  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam int STATUS_WIP_BIT = 0;
  localparam logic [7:0] SIG_VALID = 8'h5a;
  localparam logic [7:0] BUS_IDLE = 8'hff;
  localparam logic [2:0] DET_LAST_SLOT = 3'h4;
  localparam logic [2:0] HDR_CNT_LO = 3'h2;
  localparam logic [2:0] HDR_CNT_HI = 3'h3;
  localparam logic [2:0] ENT_LAST = 3'h5;
  localparam logic [15:0] ENTRY_BYTES = 16'h0006;
  localparam logic [1:0] PRESENT = 2'h1;
  localparam logic [1:0] ABSENT = 2'h0;
  localparam logic [1:0] WIDTH_UNDET = 2'h0;
  localparam logic [5:0] PORT_NT_LINK = 6'h38;

  function automatic logic port_code_ok(input logic [5:0] c);
    return (!c[5] && !c[2]) || (c == PORT_NT_LINK);
  endfunction

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_STAT = 4'h1,
    ST_GAP = 4'h2,
    ST_DET = 4'h3,
    ST_HDR = 4'h4,
    ST_ENT = 4'h5,
    ST_WREN = 4'h6,
    ST_ACC = 4'h7
  } secl_state_t;

endpackage
